// file: dv/mfpm_board.sv
`timescale 1ns/10ps
// Board side: pull-ups plus optional external drivers
module mfpm_board #(parameter NPINS = 15) (
   input  wire [NPINS-1:0] pin_oe,
   input  wire [NPINS-1:0] ext_level,
   output wire [NPINS-1:0] pin_lvl
);
   // Wired-AND of the board level and the device pull-down
   assign pin_lvl = ext_level & ~pin_oe;
endmodule // mfpm_board

// file: dv/mfpm_props.sv
`timescale 1ns/10ps
// Port-level checks for the pin block
module mfpm_props #(parameter NPINS = 15) (
   input wire             ref_clk,
   input wire             sys_rst,
   input wire [3:0]       reg_addr,
   input wire [31:0]      reg_wdata,
   input wire             reg_wr,
   input wire             reg_rd,
   input wire [31:0]      reg_rdata,
   input wire [NPINS-1:0] pin_in,
   input wire [NPINS-1:0] pin_out,
   input wire [NPINS-1:0] pin_oe,
   input wire             startup_active,
   input wire             startup_config,
   input wire             id_strap_one,
   input wire             step_pulse,
   input wire             ext_pwm_out,
   input wire [4:0]       converter_channel_select,
   input wire             converter_start
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Pins are pulled low only, never driven high
   open_drain_a: assert property (pin_out == 0) else $error("pin driven high");
   startup_hold_a: assert property (startup_active && $past(startup_active) |-> !pin_oe[0])
      else $error("pin 0 driven during start-up");
   startup_sample_a: assert property ($past(startup_active) |-> startup_config == $past(pin_in[0], 2))
      else $error("start-up sample wrong");
   read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0) else $error("read data outside slot");
   conv_start_a: assert property (converter_start |-> $past(reg_wr) && $past(reg_addr) == 4'h4
      && $past(reg_wdata[5]) ##1 !converter_start) else $error("bad conversion start");
   conv_chan_a: assert property ($changed(converter_channel_select) |-> $past(reg_wr)
      && $past(reg_addr) == 4'h4) else $error("channel changed without write");
   step_once_a: assert property (step_pulse |-> $past(pin_in[12], 2) && !$past(pin_in[12], 3) ##1 !step_pulse)
      else $error("bad step pulse");
   pwm_pass_a: assert property (ext_pwm_out |-> $past(pin_in[9], 2)) else $error("pwm without input");
   id_follow_a: assert property ($changed(id_strap_one) |-> id_strap_one == $past(pin_in[9])
      || id_strap_one == $past(pin_in[9], 2)) else $error("id bit not from pin");
endmodule // mfpm_props

bind mfpm_top mfpm_props #(.NPINS(NPINS)) u_props (
   .ref_clk                  (ref_clk),
   .sys_rst                  (sys_rst),
   .reg_addr                 (reg_addr),
   .reg_wdata                (reg_wdata),
   .reg_wr                   (reg_wr),
   .reg_rd                   (reg_rd),
   .reg_rdata                (reg_rdata),
   .pin_in                   (pin_in),
   .pin_out                  (pin_out),
   .pin_oe                   (pin_oe),
   .startup_active           (startup_active),
   .startup_config           (startup_config),
   .id_strap_one             (id_strap_one),
   .step_pulse               (step_pulse),
   .ext_pwm_out              (ext_pwm_out),
   .converter_channel_select (converter_channel_select),
   .converter_start          (converter_start)
);

// file: dv/multi_function_pin_mux_bench.sv
`timescale 1ns/10ps
`include "mfpm_defs.vh"
module multi_function_pin_mux_bench;
   reg         clk = 0, rst = 1, wr_q = 0, rd_q = 0;
   reg  [3:0]  a_q = 0;
   reg  [31:0] d_q = 0;
   reg  [14:0] ext = 15'h7FFF;
   reg         su = 0, irq = 0, ax1 = 0, ax2 = 0, cst = 0, slv = 0, bsy = 0;
   wire [31:0] rdat;
   wire [14:0] lvl, oe;
   wire [4:0]  chan;
   wire        cfg, id1, id2, stp, pwm, cgo;
   integer     n_fail = 0, num_checks = 0, cyc = 0, m, p, k;
   mfpm_top uut (.ref_clk(clk), .sys_rst(rst), .reg_addr(a_q), .reg_wdata(d_q), .reg_wr(wr_q), .reg_rd(rd_q),
      .reg_rdata(rdat), .pin_in(lvl), .pin_out(), .pin_oe(oe), .startup_active(su), .irq_controller_output(irq),
      .aux_pulse_gen_one(ax1), .aux_pulse_gen_two(ax2), .converter_status_output(cst), .converter_busy(bsy),
      .startup_config(cfg), .id_strap_one(id1), .id_strap_two(id2), .step_pulse(stp), .ext_pwm_out(pwm),
      .slave_ctrl_level(slv), .converter_channel_select(chan), .converter_start(cgo));
   mfpm_board board (.pin_oe(oe), .ext_level(ext), .pin_lvl(lvl));
   always #5 clk = ~clk;
   // Cycle ceiling
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         conclude;
      end
   end
   task conclude;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk) {a_q, d_q, wr_q} <= {a, d, 1'h1};
         @(posedge clk) wr_q <= 1'h0;
      end
   endtask
   task rd(input [3:0] a, input [31:0] exp);
      begin
         @(posedge clk) {a_q, rd_q} <= {a, 1'h1};
         @(posedge clk) rd_q <= 1'h0;
         #1 chk(rdat, exp);
      end
   endtask
   // Main sequence
   initial begin
      tick(16);
      rst <= 1'h0;
      rd(`MFPM_A_OE, 0);
      rd(`MFPM_A_MODE_LO, 0);
      chk(oe, 0);
      rd(`MFPM_A_INPUT, 32'h7EFF);
      wr(`MFPM_A_CDAC, 1);
      tick(3);
      rd(`MFPM_A_INPUT, 32'h7FFF);
      wr(`MFPM_A_OE, 1);
      for (m = 0; m < 8; m = m + 1) begin
         wr(`MFPM_A_MODE_LO, m);
         for (p = 0; p < 16; p = p + 1) begin
            wr(`MFPM_A_LEVEL, 32'h7FFE | p[3]);
            @(posedge clk) {irq, ax1, ax2} <= p[2:0];
            tick(3);
            k = m[1:0] == 0 ? p[3] : m[1:0] == 1 ? p[2] : m[1:0] == 2 ? p[1] : p[0];
            chk(oe[0], {31'h0, k[0] ~^ m[2]});
         end
      end
      wr(`MFPM_A_MODE_LO, 0);
      wr(`MFPM_A_LEVEL, 32'h7FFE);
      tick(3);
      chk(oe, 1);
      rd(`MFPM_A_INPUT, 32'h7FFE);
      wr(`MFPM_A_ADC, 32'h33);
      #1 chk({cgo, chan}, 6'h33);
      tick(1);
      chk(cgo, 0);
      @(posedge clk) su <= 1'h1;
      tick(4);
      chk({oe[0], cfg}, 1);
      rd(`MFPM_A_STATUS, 32'h4);
      @(posedge clk) su <= 1'h0;
      tick(3);
      chk(oe[0], 1);
      @(posedge clk) ext[10] <= 1'h0;
      wr(`MFPM_A_SPECIAL, 1);
      tick(4);
      rd(`MFPM_A_STATUS, 32'h5);
      chk({id2, id1}, 1);
      wr(`MFPM_A_SPECIAL, 2);
      @(posedge clk) ext[12] <= 1'h0;
      tick(3);
      @(posedge clk) ext[12] <= 1'h1;
      k = 0;
      repeat (8) begin
         tick(1);
         k = k + stp;
      end
      chk(k, 1);
      wr(`MFPM_A_SPECIAL, 4);
      for (k = 0; k < 2; k = k + 1) begin
         @(posedge clk) ext[9] <= k[0];
         tick(3);
         chk(pwm, k);
      end
      wr(`MFPM_A_SPECIAL, 24);
      wr(`MFPM_A_OE, 32'h60);
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge clk) {cst, slv} <= k[1:0];
         tick(3);
         chk(oe[6:5], {30'h0, ~k[1:0]});
      end
      wr(`MFPM_A_MODE_LO, 32'h120000);
      tick(3);
      chk(oe[6:5], 3);
      wr(4'hF, 32'hFFFF);
      rd(4'hF, 0);
      rd(`MFPM_A_OE, 32'h60);
      wr(`MFPM_A_MODE_HI, 32'h7FFF);
      @(posedge clk) bsy <= 1'h1;
      rd(`MFPM_A_STATUS, 32'hD);
      // Mid-run reset must clear enables and modes again
      @(posedge clk) rst <= 1'h1;
      @(posedge clk) rst <= 1'h0;
      rd(`MFPM_A_OE, 0);
      rd(`MFPM_A_MODE_HI, 0);
      chk(oe, 0);
      rd(`MFPM_A_INPUT, 32'h7AFF);
      rd(`MFPM_A_STATUS, 32'h8);
      conclude;
   end
endmodule // multi_function_pin_mux_bench

// file: verilog/mfpm_defs.vh
// Summary of operation
// - Pin 8 digital input disabled after reset
// - Drive pin only when its enable set
// - Three-bit function select per pin
// - Pin 0 detects start-up config first
// - Pin 0 codes pick source, bit2 inverts
// - Pin 0 convertible by ADC while output
// - Pin 0 level always readable
// - Pin 0 is open drain, pulls low
// - Serial output drives last written level
// - Serial input exposes sampled pin level
// - Interrupt function routes controller output
// - ID pins set two identification bits
// - Step request advances sequencer one step
// - External PWM input passes to bridges
// - Converter status output drives pin
// - Master mode uses slave-control pin
// - Every digital output may be inverted
`ifndef MFPM_DEFS_VH
`define MFPM_DEFS_VH
`define MFPM_A_OE        4'h0
`define MFPM_A_LEVEL     4'h1
`define MFPM_A_INPUT     4'h2
`define MFPM_A_CDAC      4'h3
`define MFPM_A_ADC       4'h4
`define MFPM_A_STATUS    4'h5
`define MFPM_A_MODE_LO   4'h6
`define MFPM_A_MODE_HI   4'h7
`define MFPM_A_SPECIAL   4'h8
`define MFPM_CDAC_EN8    0
`define MFPM_ADC_START   5
`define MFPM_SP_ID       0
`define MFPM_SP_STEP     1
`define MFPM_SP_PWM      2
`define MFPM_SP_A2DO     3
`define MFPM_SP_MASTER   4
`define MFPM_PIN_ID1     9
`define MFPM_PIN_ID2     10
`define MFPM_PIN_STEP    12
`define MFPM_PIN_PWM     9
`define MFPM_PIN_A2DO    6
`define MFPM_PIN_SLAVE   5
`define MFPM_SRC_SERIAL  2'h0
`define MFPM_SRC_IRQ     2'h1
`define MFPM_SRC_AUX1    2'h2
`define MFPM_SRC_AUX2    2'h3
`endif

// file: verilog/mfpm_edge.v
`timescale 1ns/10ps
// Rising-edge pulse from a synchronous level
module mfpm_edge (
   ref_clk,
   sys_rst,
   level_in,
   pulse_out
);
   input  wire ref_clk;
   input  wire sys_rst;
   input  wire level_in;
   output wire pulse_out;

   reg prev_q;

   // Remember last level
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) prev_q <= 1'b0;
      else prev_q <= level_in;
   end

   assign pulse_out = level_in & ~prev_q;
endmodule // mfpm_edge

// file: verilog/mfpm_pin_sel.v
`timescale 1ns/10ps
`include "mfpm_defs.vh"
// Per-pin source selection with optional inversion
module mfpm_pin_sel (
   mode,
   serial_level,
   irq_in,
   aux1_in,
   aux2_in,
   level_out
);
   input  wire [2:0] mode;
   input  wire       serial_level;
   input  wire       irq_in;
   input  wire       aux1_in;
   input  wire       aux2_in;
   output reg        level_out;

   reg src;

   // Low bits pick source, top bit inverts
   always @* begin
      case (mode[1:0])
         `MFPM_SRC_SERIAL: src = serial_level;
         `MFPM_SRC_IRQ:    src = irq_in;
         `MFPM_SRC_AUX1:   src = aux1_in;
         default:          src = aux2_in;
      endcase
      level_out = src ^ mode[2];
   end
endmodule // mfpm_pin_sel

// file: verilog/mfpm_top.v
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "mfpm_defs.vh"
// General-purpose pin block: output mux, open-drain drive, input sampling
module mfpm_top #(
   parameter NPINS = 15
) (
   ref_clk,
   sys_rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   pin_in,
   pin_out,
   pin_oe,
   startup_active,
   irq_controller_output,
   aux_pulse_gen_one,
   aux_pulse_gen_two,
   converter_status_output,
   converter_busy,
   startup_config,
   id_strap_one,
   id_strap_two,
   step_pulse,
   ext_pwm_out,
   slave_ctrl_level,
   converter_channel_select,
   converter_start
);
   input  wire             ref_clk;
   input  wire             sys_rst;
   input  wire [3:0]       reg_addr;
   input  wire [31:0]      reg_wdata;
   input  wire             reg_wr;
   input  wire             reg_rd;
   output reg  [31:0]      reg_rdata;
   input  wire [NPINS-1:0] pin_in;
   output reg  [NPINS-1:0] pin_out;
   output reg  [NPINS-1:0] pin_oe;
   input  wire             startup_active;
   input  wire             irq_controller_output;
   input  wire             aux_pulse_gen_one;
   input  wire             aux_pulse_gen_two;
   input  wire             converter_status_output;
   input  wire             converter_busy;
   output reg              startup_config;
   output reg              id_strap_one;
   output reg              id_strap_two;
   output reg              step_pulse;
   output reg              ext_pwm_out;
   input  wire             slave_ctrl_level;
   output reg  [4:0]       converter_channel_select;
   output reg              converter_start;

   reg  [NPINS-1:0]   pin_output_enable_mask_q;
   reg  [NPINS-1:0]   serial_level_q;
   reg  [NPINS-1:0]   pin_sample_q;
   reg  [3*NPINS-1:0] pin_function_select_q;
   reg                pin8_digital_input_enable_q;
   reg  [4:0]         special_q;
   reg  [NPINS-1:0]   mux_level;
   reg  [NPINS-1:0]   pin_out_d;
   reg  [NPINS-1:0]   pin_oe_d;
   reg  [31:0]        rdata_d;
   wire [NPINS-1:0]   sel_level;
   wire               step_edge;

   // Register writes; reset clears enables and modes
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_output_enable_mask_q    <= {NPINS{1'b0}};
         pin_function_select_q       <= {3*NPINS{1'b0}};
         serial_level_q              <= {NPINS{1'b1}};
         pin8_digital_input_enable_q <= 1'b0;
         special_q                   <= 5'h00;
         converter_channel_select    <= 5'h00;
         converter_start             <= 1'b0;
      end else begin
         converter_start <= 1'b0;
         if (reg_wr) begin
            case (reg_addr)
               `MFPM_A_OE:      pin_output_enable_mask_q <= reg_wdata[NPINS-1:0];
               `MFPM_A_LEVEL:   serial_level_q <= reg_wdata[NPINS-1:0];
               `MFPM_A_CDAC:    pin8_digital_input_enable_q <= reg_wdata[`MFPM_CDAC_EN8];
               `MFPM_A_ADC: begin
                  converter_channel_select <= reg_wdata[4:0];
                  converter_start          <= reg_wdata[`MFPM_ADC_START];
               end
               `MFPM_A_MODE_LO: pin_function_select_q[29:0]  <= reg_wdata[29:0];
               `MFPM_A_MODE_HI: pin_function_select_q[44:30] <= reg_wdata[14:0];
               `MFPM_A_SPECIAL: special_q <= reg_wdata[4:0];
               default: ;
            endcase
         end
      end
   end

   // One source selector per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sel
         mfpm_pin_sel u_sel (
            .mode         (pin_function_select_q[3*gi+2:3*gi]),
            .serial_level (serial_level_q[gi]),
            .irq_in       (irq_controller_output),
            .aux1_in      (aux_pulse_gen_one),
            .aux2_in      (aux_pulse_gen_two),
            .level_out    (sel_level[gi])
         );
      end
   endgenerate

   // Special outputs override the selected source
   always @* begin
      mux_level = sel_level;
      if (special_q[`MFPM_SP_A2DO])
         mux_level[`MFPM_PIN_A2DO] = converter_status_output ^ pin_function_select_q[3*`MFPM_PIN_A2DO+2];
      if (special_q[`MFPM_SP_MASTER])
         mux_level[`MFPM_PIN_SLAVE] = slave_ctrl_level ^ pin_function_select_q[3*`MFPM_PIN_SLAVE+2];
   end

   // Open-drain drive: enable only when output enabled and level low
   always @* begin
      pin_out_d = {NPINS{1'b0}};
      pin_oe_d  = pin_output_enable_mask_q & ~mux_level;
      if (startup_active)
         pin_oe_d[0] = 1'b0;
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out <= {NPINS{1'b0}};
         pin_oe  <= {NPINS{1'b0}};
      end else begin
         pin_out <= pin_out_d;
         pin_oe  <= pin_oe_d;
      end
   end

   // Sample every pin each cycle; pin 8 gated by its enable
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) pin_sample_q <= {NPINS{1'b0}};
      else begin
         pin_sample_q    <= pin_in;
         pin_sample_q[8] <= pin_in[8] & pin8_digital_input_enable_q;
      end
   end

   mfpm_edge u_step (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .level_in  (pin_sample_q[`MFPM_PIN_STEP]),
      .pulse_out (step_edge)
   );

   // Special inputs: straps, step request, external PWM, start-up level
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         id_strap_one   <= 1'b0;
         id_strap_two   <= 1'b0;
         step_pulse     <= 1'b0;
         ext_pwm_out    <= 1'b0;
         startup_config <= 1'b0;
      end else begin
         if (special_q[`MFPM_SP_ID]) begin
            id_strap_one <= pin_sample_q[`MFPM_PIN_ID1];
            id_strap_two <= pin_sample_q[`MFPM_PIN_ID2];
         end
         step_pulse  <= step_edge & special_q[`MFPM_SP_STEP];
         ext_pwm_out <= pin_sample_q[`MFPM_PIN_PWM] & special_q[`MFPM_SP_PWM];
         if (startup_active)
            startup_config <= pin_sample_q[0];
      end
   end

   // Read mux
   always @* begin
      rdata_d = 32'h00000000;
      case (reg_addr)
         `MFPM_A_OE:      rdata_d[NPINS-1:0] = pin_output_enable_mask_q;
         `MFPM_A_LEVEL:   rdata_d[NPINS-1:0] = serial_level_q;
         `MFPM_A_INPUT:   rdata_d[NPINS-1:0] = pin_sample_q;
         `MFPM_A_CDAC:    rdata_d[0] = pin8_digital_input_enable_q;
         `MFPM_A_ADC:     rdata_d[4:0] = converter_channel_select;
         `MFPM_A_STATUS:  rdata_d[3:0] = {converter_busy, startup_config, id_strap_two, id_strap_one};
         `MFPM_A_MODE_LO: rdata_d[29:0] = pin_function_select_q[29:0];
         `MFPM_A_MODE_HI: rdata_d[14:0] = pin_function_select_q[44:30];
         `MFPM_A_SPECIAL: rdata_d[4:0] = special_q;
         default:         rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) reg_rdata <= 32'h00000000;
      else if (reg_rd) reg_rdata <= rdata_d;
      else reg_rdata <= 32'h00000000;
   end
endmodule // mfpm_top
